//--- design/rc_io_params.svh
`ifndef RC_IO_PARAMS_SVH
`define RC_IO_PARAMS_SVH
// port widths
`define FIRST_PORT_W 8
`define FIRST_LOW_W 4
`define SECOND_OUT_W 2
`define SECOND_IN_W 3
`define THIRD_PORT_W 4
// pull-down control layout
`define PD_LOW_W 7
`define PD_LOW_SECOND_POS 0
`define PD_LOW_THIRD_POS 3
`define PD_HIGH_W 4
`define PD_HIGH_UPPER_POS 2
// reset values
`define PD_LOW_RST 7'h00
`define PD_HIGH_RST 4'h0
`define LATCH_RST 1'b0
// status / mask bit positions
`define ST_WAKE_POS 0
`define ST_SKIP_POS 1
`define ST_W 2
`endif

//--- design/rc_io_pkg.sv
`default_nettype none
`include "rc_io_params.svh"
package rc_io_pkg;
  // ==========================================
  // port command carried from the cpu
  typedef enum logic [8:0] {
    CMD_NONE = 9'h000,
    CMD_SET_BIT = 9'h001,
    CMD_CLR_BIT = 9'h002,
    CMD_CLR_ALL = 9'h004,
    CMD_TEST_SKIP = 9'h008,
    CMD_WR_SECOND = 9'h010,
    CMD_RD_SECOND = 9'h020,
    CMD_WR_THIRD = 9'h040,
    CMD_RD_THIRD = 9'h080,
    CMD_CARRIER = 9'h100
  } port_cmd_e;
  // one instruction request
  typedef struct packed {
    port_cmd_e cmd;
    logic [2:0] digit;
    logic [3:0] acc;
    logic carrier_val;
  } port_req_s;
  // pull-down settings
  typedef struct packed {
    logic [`PD_LOW_W-1:0] low;
    logic [`PD_HIGH_W-1:0] high;
  } pd_cfg_s;
endpackage
`default_nettype wire

//--- design/od_pin_bank.sv
`default_nettype none
`include "rc_io_params.svh"
module od_pin_bank
  import rc_io_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] latch_set,
  input wire logic [W-1:0] latch_clr,
  input wire logic [W-1:0] pin_i,
  input wire logic [W-1:0] pd_en,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe_n,
  output logic [W-1:0] pd_on,
  output logic [W-1:0] wake_lvl,
  output logic [W-1:0] latch_q
);
  // ==========================================
  // per-bit latches, one generate loop
  logic [W-1:0] latch_r;
  logic [W-1:0] latch_nxt;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : bit_g
      // set wins over clear in the same cycle
      always_comb begin
        latch_nxt[g] = latch_r[g];
        if (latch_clr[g]) begin
          latch_nxt[g] = 1'b0;
        end
        if (latch_set[g]) begin
          latch_nxt[g] = 1'b1;
        end
      end
    end
  endgenerate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_r <= {W{`LATCH_RST}};
    end else begin
      latch_r <= latch_nxt;
    end
  end
  // high-side only: drive one when latch set, float otherwise
  assign pin_o = {W{1'b1}};
  assign pin_oe_n = ~latch_r;
  assign latch_q = latch_r;
  // pull-down and wake sense share one enable
  assign pd_on = pd_en;
  assign wake_lvl = pd_en & pin_i;
endmodule
`default_nettype wire

//--- design/carrier_pin.sv
`default_nettype none
`include "rc_io_params.svh"
module carrier_pin
  import rc_io_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic val,
  output logic pin
);
  // ==========================================
  // push-pull carrier level
  logic pin_r;
  logic pin_nxt;
  always_comb begin
    pin_nxt = load ? val : pin_r;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end
  assign pin = pin_r;
endmodule
`default_nettype wire

//--- design/remote_ctrl_io_ports.sv
// The implementer's own choices: the strobed register port and the address map.
`default_nettype none
`include "rc_io_params.svh"
// Function
// - all eight first-port bits individually set/clear latches
// - pull-down enable also arms high wakeup
// - second port: two latches, three inputs
// - second port third pin input only
// - third port group write and read
// - carrier pin push-pull set and clear
// - open-drain pins float until latch one
// - high control bit 2 gates upper pulldowns
// - low control bits gate second/third pins
// - digit register selects first port bit
module remote_ctrl_io_ports
  import rc_io_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inst_en,
  input wire port_req_s req,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [3:0] rd_data,
  output logic rd_valid,
  output logic skip,
  input wire logic [`FIRST_PORT_W-1:0] first_i,
  output logic [`FIRST_PORT_W-1:0] first_o,
  output logic [`FIRST_PORT_W-1:0] first_oe_n,
  output logic [3:0] first_pd_on,
  input wire logic [`SECOND_IN_W-1:0] second_i,
  output logic [`SECOND_OUT_W-1:0] second_o,
  output logic [`SECOND_OUT_W-1:0] second_oe_n,
  output logic [`SECOND_IN_W-1:0] second_pd_on,
  input wire logic [`THIRD_PORT_W-1:0] third_i,
  output logic [`THIRD_PORT_W-1:0] third_o,
  output logic [`THIRD_PORT_W-1:0] third_oe_n,
  output logic [`THIRD_PORT_W-1:0] third_pd_on,
  output logic carrier_out_pin,
  output logic wake,
  output logic irq
);
  // ==========================================
  // register offsets of the side port
  // offset 4 is a read-only view of the first port latches: noise can
  // flip a latch between refreshes, so software compares the latches
  // with what it last meant to write
  // offsets 5 to 15 read zero and ignore writes
  localparam logic [3:0] A_PD_LOW = 4'h0;
  localparam logic [3:0] A_PD_HIGH = 4'h1;
  localparam logic [3:0] A_STATUS = 4'h2;
  localparam logic [3:0] A_MASK = 4'h3;

  // ==========================================
  // decoded instruction strobes
  // the cpu runs at the slower instruction rate; inst_en is the
  // one-cycle enable from its divider, so each port action below
  // happens on exactly one system clock edge per instruction
  // commands seen while inst_en is low are ignored
  logic go; // command accepted this cycle
  logic [7:0] sel; // one-hot first port bit from digit
  logic [7:0] first_set;
  logic [7:0] first_clr;
  logic [1:0] second_set;
  logic [1:0] second_clr;
  logic [3:0] third_set;
  logic [3:0] third_clr;
  assign go = inst_en;
  // digit register picks the bit
  assign sel = 8'h01 << req.digit;
  always_comb begin
    first_set = 8'h00;
    first_clr = 8'h00;
    second_set = 2'h0;
    second_clr = 2'h0;
    third_set = 4'h0;
    third_clr = 4'h0;
    if (go) begin
      case (req.cmd)
        CMD_SET_BIT: begin
          first_set = sel;
        end
        CMD_CLR_BIT: begin
          first_clr = sel;
        end
        CMD_CLR_ALL: begin
          first_clr = 8'hff;
        end
        CMD_WR_SECOND: begin
          second_set = req.acc[1:0];
          second_clr = ~req.acc[1:0];
        end
        CMD_WR_THIRD: begin
          third_set = req.acc;
          third_clr = ~req.acc;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // pull-down control registers
  // both control registers reset to zero, so no pull-down and no
  // wakeup sense is armed until software asks for it
  // status is sticky, write one to clear; mask has the same layout
  // bit 0 records an armed pin seen high, bit 1 a taken skip
  logic [`PD_LOW_W-1:0] pd_low_r;
  logic [`PD_LOW_W-1:0] pd_low_nxt;
  logic [`PD_HIGH_W-1:0] pd_high_r;
  logic [`PD_HIGH_W-1:0] pd_high_nxt;
  logic [`ST_W-1:0] status_r;
  logic [`ST_W-1:0] status_nxt;
  logic [`ST_W-1:0] mask_r;
  logic [`ST_W-1:0] mask_nxt;
  logic [`ST_W-1:0] ev; // event pulses
  // software writes only
  always_comb begin
    pd_low_nxt = pd_low_r;
    pd_high_nxt = pd_high_r;
    mask_nxt = mask_r;
    if (reg_wr && reg_addr == A_PD_LOW) begin
      pd_low_nxt = reg_wdata[`PD_LOW_W-1:0];
    end
    if (reg_wr && reg_addr == A_PD_HIGH) begin
      pd_high_nxt = reg_wdata[`PD_HIGH_W-1:0];
    end
    if (reg_wr && reg_addr == A_MASK) begin
      mask_nxt = reg_wdata[`ST_W-1:0];
    end
    // write one clears, new event wins
    status_nxt = status_r;
    if (reg_wr && reg_addr == A_STATUS) begin
      status_nxt = status_r & ~reg_wdata[`ST_W-1:0];
    end
    status_nxt = status_nxt | ev;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pd_low_r <= `PD_LOW_RST;
      pd_high_r <= `PD_HIGH_RST;
      status_r <= '0;
      mask_r <= '0;
    end else begin
      pd_low_r <= pd_low_nxt;
      pd_high_r <= pd_high_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
    end
  end
  // level interrupt
  // high as long as any unmasked status bit is set; a pin that stays
  // high keeps setting the wake bit, so clearing it only sticks once
  // the key is released
  assign irq = |(status_r & mask_r);

  // ==========================================
  // pull-down fan-out per port
  // the low nibble of the first port is output only and never gets a
  // pull-down; the upper nibble shares a single enable bit, so its
  // four pins are armed or disarmed together
  // low control bits 2:0 cover the second port, 6:3 the third port
  logic [7:0] first_pd_en;
  logic [1:0] second_pd_en_out;
  logic second_pd_in_only;
  logic [3:0] third_pd_en;
  // one control bit gates the whole upper nibble
  assign first_pd_en = {{4{pd_high_r[`PD_HIGH_UPPER_POS]}}, 4'h0};
  assign second_pd_en_out = pd_low_r[`PD_LOW_SECOND_POS +: 2];
  assign second_pd_in_only = pd_low_r[`PD_LOW_SECOND_POS + 2];
  assign third_pd_en = pd_low_r[`PD_LOW_THIRD_POS +: 4];

  // ==========================================
  // pin banks
  // every open-drain pin only ever drives high; a latch of zero lets
  // the pin float so a key or the pull-down sets its level, which is
  // why software must clear a latch before reading that pin
  // the second port bank covers only its two latched pins
  logic [7:0] first_wake;
  logic [7:0] first_pd_all;
  logic [7:0] first_latch;
  logic [1:0] second_wake;
  logic [3:0] third_wake;
  od_pin_bank #(.W(8)) first_bank (
    .sys_clk(sys_clk),
    .rst(rst),
    .latch_set(first_set),
    .latch_clr(first_clr),
    .pin_i(first_i),
    .pd_en(first_pd_en),
    .pin_o(first_o),
    .pin_oe_n(first_oe_n),
    .pd_on(first_pd_all),
    .wake_lvl(first_wake),
    .latch_q(first_latch)
  );
  assign first_pd_on = first_pd_all[7:4];
  od_pin_bank #(.W(2)) second_bank (
    .sys_clk(sys_clk),
    .rst(rst),
    .latch_set(second_set),
    .latch_clr(second_clr),
    .pin_i(second_i[1:0]),
    .pd_en(second_pd_en_out),
    .pin_o(second_o),
    .pin_oe_n(second_oe_n),
    .pd_on(second_pd_on[1:0]),
    .wake_lvl(second_wake),
    .latch_q()
  );
  // third pin of the second port has no latch at all
  assign second_pd_on[2] = second_pd_in_only;
  od_pin_bank #(.W(4)) third_bank (
    .sys_clk(sys_clk),
    .rst(rst),
    .latch_set(third_set),
    .latch_clr(third_clr),
    .pin_i(third_i),
    .pd_en(third_pd_en),
    .pin_o(third_o),
    .pin_oe_n(third_oe_n),
    .pd_on(third_pd_on),
    .wake_lvl(third_wake),
    .latch_q()
  );
  // carrier pin set / clear
  // push-pull, so unlike the ports it always drives a level; one
  // command carries the level, covering both set and clear
  carrier_pin carrier_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(go && req.cmd == CMD_CARRIER),
    .val(req.carrier_val),
    .pin(carrier_out_pin)
  );

  // ==========================================
  // wakeup level, combined over all armed pins
  // combinational on purpose: a sleeping core needs the level even
  // when no instruction is running; a pin driven high by its own
  // latch while armed also counts, so software clears it first
  logic wake_any;
  logic skip_ev;
  assign wake_any = (|first_wake) | (|second_wake) | (second_pd_in_only & second_i[2])
    | (|third_wake);
  assign wake = wake_any;

  // ==========================================
  // instruction read data, registered
  // rd_data holds until the next read, rd_valid and skip stand for
  // one cycle only; the cpu takes them on the edge after its command
  // test-and-skip only looks at the upper nibble, which has an input
  logic [3:0] rd_data_r;
  logic [3:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic skip_r;
  logic skip_nxt;
  // pin read reflects pad level; latch must be zero for a true input
  always_comb begin
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    skip_nxt = 1'b0;
    if (go) begin
      case (req.cmd)
        CMD_RD_SECOND: begin
          rd_data_nxt = {1'b0, second_i};
          rd_valid_nxt = 1'b1;
        end
        CMD_RD_THIRD: begin
          rd_data_nxt = third_i;
          rd_valid_nxt = 1'b1;
        end
        CMD_TEST_SKIP: begin
          // skip when selected upper pin reads low
          skip_nxt = req.digit[2] && !first_i[req.digit];
        end
        default: begin
        end
      endcase
    end
  end
  assign skip_ev = skip_nxt;
  assign ev = {skip_ev, wake_any};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_r <= 4'h0;
      rd_valid_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      skip_r <= skip_nxt;
    end
  end
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign skip = skip_r;

  // ==========================================
  // register read port, data one cycle later
  // the data stand for one cycle and drop back to zero, so a master
  // must take them in the cycle right after its read strobe
  // reading has no side effect, status is only cleared by writes
  logic [7:0] reg_rdata_r;
  logic [7:0] reg_rdata_nxt;
  always_comb begin
    reg_rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        A_PD_LOW: reg_rdata_nxt = {1'b0, pd_low_r};
        A_PD_HIGH: reg_rdata_nxt = {4'h0, pd_high_r};
        A_STATUS: reg_rdata_nxt = {6'h00, status_r};
        A_MASK: reg_rdata_nxt = {6'h00, mask_r};
        // first port latches shown for software refresh checks
        4'h4: reg_rdata_nxt = first_latch;
        default: reg_rdata_nxt = 8'h00; // unmapped reads zero
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end
  assign reg_rdata = reg_rdata_r;
endmodule
`default_nettype wire

//--- testbench/rc_io_properties.sv
`default_nettype none
`include "rc_io_params.svh"
module rc_io_properties
  import rc_io_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inst_en,
  input wire port_req_s req,
  input wire logic [3:0] rd_data,
  input wire logic rd_valid,
  input wire logic skip,
  input wire logic [7:0] first_i,
  input wire logic [7:0] first_oe_n,
  input wire logic [3:0] first_pd_on,
  input wire logic [2:0] second_i,
  input wire logic [1:0] second_oe_n,
  input wire logic [2:0] second_pd_on,
  input wire logic [3:0] third_i,
  input wire logic [3:0] third_oe_n,
  input wire logic [3:0] third_pd_on,
  input wire logic carrier_out_pin,
  input wire logic wake,
  input wire logic irq
);
  // ==========
  // helpers
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic [2:0] dg; // digit of the request
  logic sel_pin; // pin picked by the digit
  assign dg = req.digit;
  assign sel_pin = first_i[dg];
  // ==========
  // checks
  bit_set_a: assert property (inst_en && req.cmd == CMD_SET_BIT |=>
    !first_oe_n[$past(dg)]) else $error("bit set lost");
  clr_all_a: assert property (inst_en && req.cmd == CMD_CLR_ALL |=>
    &first_oe_n && $stable(third_oe_n)) else $error("clear all wrong");
  carrier_set_a: assert property (inst_en && req.cmd == CMD_CARRIER |=>
    carrier_out_pin == $past(req.carrier_val)) else $error("carrier wrong");
  third_wr_a: assert property (inst_en && req.cmd == CMD_WR_THIRD |=>
    third_oe_n == ~$past(req.acc)) else $error("third write wrong");
  third_rd_a: assert property (inst_en && req.cmd == CMD_RD_THIRD |=>
    rd_valid && rd_data == $past(third_i)) else $error("third read wrong");
  // low digits must never skip: they have no input path
  skip_pin_a: assert property (inst_en && req.cmd == CMD_TEST_SKIP |=>
    skip == ($past(dg[2]) && !$past(sel_pin))) else $error("skip wrong");
  wake_lvl_a: assert property (wake == |{first_pd_on & first_i[7:4],
    second_pd_on & second_i, third_pd_on & third_i}) else $error("wake wrong");
  reset_idle_a: assert property (disable iff (1'h0) rst |=> &first_oe_n &&
    &second_oe_n && &third_oe_n && !first_pd_on && !carrier_out_pin) else $error("reset");
  skip_c: cover property (skip);
  irq_c: cover property (irq);
  wake_c: cover property (wake);
endmodule
bind remote_ctrl_io_ports rc_io_properties props (.sys_clk, .rst, .inst_en, .req, .rd_data,
  .rd_valid, .skip, .first_i, .first_oe_n, .first_pd_on, .second_i, .second_oe_n,
  .second_pd_on, .third_i, .third_oe_n, .third_pd_on, .carrier_out_pin, .wake, .irq);
`default_nettype wire

//--- testbench/key_pad_model.sv
`default_nettype none
module key_pad_model #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pd_on,
  input wire logic [W-1:0] key,
  output logic [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // pin level
  logic tog_r = 1'h0; // open pins wander so no level is trusted
  always @(posedge sys_clk) begin
    tog_r <= ~tog_r;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n[i]) pin[i] = 1'h1; // high side drive
      else if (key[i]) pin[i] = 1'h1; // key ties pin to supply
      else if (pd_on[i]) pin[i] = 1'h0; // pull-down holds low
      else pin[i] = tog_r; // left open
    end
  end
endmodule
`default_nettype wire

//--- testbench/remote_ctrl_io_ports_bench.sv
`default_nettype none
module remote_ctrl_io_ports_bench
  import rc_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // signals
  logic sys_clk = 1'h0, rst = 1'h1, inst_en = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  port_req_s req = '0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, first_o, first_oe_n;
  logic [3:0] rd_data, first_pd_on, third_o, third_oe_n, third_pd_on;
  logic [2:0] second_pd_on;
  logic [1:0] second_o, second_oe_n;
  logic [14:0] keys = 15'h0000, pins; // {first, second, third}
  logic rd_valid, skip, carrier_out_pin, wake, irq;
  int fails = 0, num_checks = 0, cyc = 0;
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  remote_ctrl_io_ports DUT (.sys_clk, .rst, .inst_en, .req, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .rd_data, .rd_valid, .skip, .first_i(pins[14:7]), .first_o,
    .first_oe_n, .first_pd_on, .second_i(pins[6:4]), .second_o, .second_oe_n, .second_pd_on,
    .third_i(pins[3:0]), .third_o, .third_oe_n, .third_pd_on, .carrier_out_pin, .wake, .irq);
  // one model for all pins; second port top pin is input only
  key_pad_model #(.W(15)) pads (.sys_clk, .oe_n({first_oe_n, 1'h1, second_oe_n, third_oe_n}),
    .pd_on({first_pd_on, 4'h0, second_pd_on, third_pd_on}), .key(keys), .pin(pins));
  // ==========
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ins(input port_cmd_e c, input logic [2:0] d, input logic [3:0] a);
    @(posedge sys_clk);
    inst_en <= 1'h1;
    req <= '{c, d, a, a[0]};
    @(posedge sys_clk);
    inst_en <= 1'h0;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard, run needs about a hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim();
    end
  end
  // ==========
  // tests
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk(first_oe_n, 8'hff);
    chk({second_oe_n, third_oe_n}, 8'h3f);
    chk({first_pd_on, third_pd_on}, 8'h00);
    chk({second_pd_on, carrier_out_pin, irq}, 8'h00);
    for (int a = 0; a < 10; a++) rd(a[3:0], 8'h00);
    $display("reset test done");
    for (int d = 0; d < 8; d++) begin
      ins(CMD_SET_BIT, d[2:0], 4'h0);
      chk(first_oe_n, 8'hff << (d + 1));
    end
    rd(4'h4, 8'hff);
    ins(CMD_CLR_BIT, 3'h3, 4'h0);
    chk(first_oe_n, 8'h08);
    ins(CMD_WR_THIRD, 3'h0, 4'ha);
    chk(third_oe_n, 8'h05);
    ins(CMD_CLR_ALL, 3'h0, 4'h0);
    chk({first_oe_n[3:0], third_oe_n}, 8'hf5);
    ins(CMD_WR_SECOND, 3'h0, 4'he);
    chk(second_oe_n, 8'h01);
    chk(first_o, 8'hff);
    chk({second_o, third_o}, 8'h3f);
    ins(CMD_WR_SECOND, 3'h0, 4'he);
    chk(second_oe_n, 8'h01);
    rd(4'h4, 8'h00);
    $display("latch test done");
    wr(4'h0, 8'h7f);
    chk({second_pd_on, third_pd_on}, 8'h7f);
    wr(4'h1, 8'h04);
    chk(first_pd_on, 8'h0f);
    ins(CMD_WR_THIRD, 3'h0, 4'h0);
    ins(CMD_WR_SECOND, 3'h0, 4'h0);
    @(posedge sys_clk) keys <= 15'h0059;
    ins(CMD_RD_THIRD, 3'h0, 4'h0);
    chk({rd_valid, rd_data}, 8'h19);
    ins(CMD_RD_SECOND, 3'h0, 4'h0);
    chk({rd_valid, rd_data}, 8'h15);
    chk(wake, 8'h01);
    $display("input test done");
    @(posedge sys_clk) keys <= 15'h1000;
    ins(CMD_TEST_SKIP, 3'h5, 4'h0);
    chk(skip, 8'h00);
    ins(CMD_TEST_SKIP, 3'h6, 4'h0);
    chk(skip, 8'h01);
    ins(CMD_TEST_SKIP, 3'h2, 4'h0);
    chk(skip, 8'h00);
    rd(4'h2, 8'h03);
    chk(irq, 8'h00);
    wr(4'h3, 8'h02);
    rd(4'h3, 8'h02);
    chk(irq, 8'h01);
    @(posedge sys_clk) keys <= 15'h0000;
    wr(4'h2, 8'h03);
    chk(irq, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h1, 8'h00);
    chk(first_pd_on, 8'h00);
    $display("wake test done");
    ins(CMD_CARRIER, 3'h0, 4'h1);
    chk(carrier_out_pin, 8'h01);
    ins(CMD_CARRIER, 3'h0, 4'h0);
    chk(carrier_out_pin, 8'h00);
    $display("carrier test done");
    end_sim();
  end
endmodule
`default_nettype wire
